// File: common/sbac_map.svh
`ifndef SBAC_MAP_SVH
`define SBAC_MAP_SVH
`define SBAC_CTL_OFFSET 12'h000
`define SBAC_DAT_OFFSET 12'h004
`define SBAC_CFG_OFFSET 12'h008
`define SBAC_CTL_RESET 8'h00
`define SBAC_BIT_MODE_HI 7
`define SBAC_BIT_MODE_LO 6
`define SBAC_BIT_LOST 5
`define SBAC_BIT_CLKSEL 4
`define SBAC_BIT_DONE 3
`define SBAC_BIT_RUN 2
`define SBAC_BIT_OVF 1
`define SBAC_BIT_MSB 0
`define SBAC_ARB_SAMPLE_BUS 9'h038
`define SBAC_ARB_SAMPLE_PSC 9'h008
`define SBAC_QUARTER_DIV 2'h3
`endif

// File: common/sbac_pkg.sv
package sbac_pkg;
  typedef enum logic [1:0] {
    SBAC_MODE_IDLE = 2'b00,
    SBAC_MODE_MEASURE = 2'b01,
    SBAC_MODE_ARB = 2'b10,
    SBAC_MODE_RSVD = 2'b11
  } sbac_mode_t;
  typedef struct packed {
    logic rx_line;
    logic internal_tx_output;
    logic prescaler_tick;
  } sbac_line_in_t;
endpackage

// File: logic/sbac_arbiter.sv
`timescale 1ns/1ps
`include "sbac_map.svh"
module sbac_arbiter (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial lines.
  input wire sbac_pkg::sbac_line_in_t line_in,
  output logic tx_pin
);
  import sbac_pkg::*;

  // Software-visible state.
  sbac_mode_t mode_reg;
  logic clksel_reg;
  logic lost_reg;
  logic done_reg;
  logic run_reg;
  logic ovf_reg;
  logic [8:0] cnt_reg;
  // Tick divider, line samples and arbitration bookkeeping.
  logic [1:0] div_reg;
  logic rx_q_reg;
  logic tx_q_reg;
  logic armed_reg;
  logic rx_low_seen_reg;

  // Decoded strobes and combinational values.
  logic wr;
  logic ctl_wr;
  logic tick;
  logic base_tick;
  logic rx_fall;
  logic rx_rise;
  logic tx_rise;
  logic tx_fall;
  logic [8:0] sample_pt;
  logic cnt_full;
  logic arb_hit;
  logic mode_arb;
  logic lost_set;
  logic lost_clr;
  logic rd_setup;
  logic [1:0] wr_mode;
  logic wr_clksel;
  logic [7:0] ctl_view;
  logic [7:0] rd_byte;

  assign wr = psel && penable && pwrite;
  assign ctl_wr = wr && (paddr == `SBAC_CTL_OFFSET);
  // Every access completes at once and nothing is refused.
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Base tick is one bus cycle or one prescaler output pulse.
  assign base_tick = clksel_reg ? line_in.prescaler_tick : 1'b1;
  assign tick = base_tick && (div_reg == `SBAC_QUARTER_DIV);

  // The divider runs freely, so a start can fall anywhere within a tick.
  // Measured lengths are therefore exact only to one tick, a trade made
  // to keep one shared divider for both clock sources.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 2'h0;
    else if (base_tick)
      div_reg <= div_reg + 2'h1;
  end

  // Samples are taken only on counter ticks so short glitches are filtered.
  assign rx_fall = tick && rx_q_reg && !line_in.rx_line;
  assign rx_rise = tick && !rx_q_reg && line_in.rx_line;
  assign tx_rise = tick && !tx_q_reg && line_in.internal_tx_output;
  assign tx_fall = tick && tx_q_reg && !line_in.internal_tx_output;
  assign sample_pt = clksel_reg ? `SBAC_ARB_SAMPLE_PSC
                                : `SBAC_ARB_SAMPLE_BUS;

  // The counter wraps past 9'h1ff; this compare feeds the overflow flag.
  assign cnt_full = (cnt_reg == 9'h1ff);
  assign arb_hit = armed_reg && (cnt_reg == sample_pt);
  assign mode_arb = (mode_reg == SBAC_MODE_ARB);

  // Both samples reset to the idle high level, so no false edge follows
  // reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_q_reg <= 1'b1;
    else if (tick)
      rx_q_reg <= line_in.rx_line;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_q_reg <= 1'b1;
    else if (tick)
      tx_q_reg <= line_in.internal_tx_output;
  end

  // Software fields.
  assign wr_mode = pwdata[`SBAC_BIT_MODE_HI:`SBAC_BIT_MODE_LO];
  assign wr_clksel = pwdata[`SBAC_BIT_CLKSEL];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= SBAC_MODE_IDLE;
    else if (ctl_wr)
      mode_reg <= sbac_mode_t'(wr_mode);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clksel_reg <= 1'b0;
    else if (ctl_wr)
      clksel_reg <= wr_clksel;
  end

  // Counter, running flag and overflow.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 9'h000;
      run_reg <= 1'b0;
      ovf_reg <= 1'b0;
      done_reg <= 1'b0;
      armed_reg <= 1'b0;
      rx_low_seen_reg <= 1'b0;
    end
    else if (ctl_wr)
    begin
      // A control write restarts the measurement from a clean state.
      cnt_reg <= 9'h000;
      ovf_reg <= 1'b0;
      done_reg <= 1'b0;
      run_reg <= 1'b0;
      armed_reg <= 1'b0;
      rx_low_seen_reg <= 1'b0;
    end
    else
    begin
      unique case (mode_reg)
        SBAC_MODE_MEASURE:
        begin
          // One-shot: once done it stays parked until the next control
          // write, so software can read a stable result.
          if (tick && !done_reg)
          begin
            if (!clksel_reg)
            begin
              if (rx_fall)
              begin
                if (run_reg)
                begin
                  run_reg <= 1'b0;
                  done_reg <= 1'b1;
                end
                else
                  run_reg <= 1'b1;
              end
            end
            else if (!run_reg && !line_in.rx_line)
              run_reg <= 1'b1;
            else if (run_reg && rx_rise)
            begin
              run_reg <= 1'b0;
              done_reg <= 1'b1;
            end
            if (run_reg)
            begin
              cnt_reg <= cnt_reg + 9'h001;
              if (cnt_full)
                ovf_reg <= 1'b1;
            end
          end
        end
        SBAC_MODE_ARB:
        begin
          if (tick)
          begin
            // Every rising edge reloads the bit timer, so each recessive
            // bit gets its own sample.
            if (tx_rise)
            begin
              cnt_reg <= 9'h000;
              run_reg <= 1'b1;
              armed_reg <= 1'b1;
              rx_low_seen_reg <= 1'b0;
            end
            else if (run_reg && tx_fall && !rx_low_seen_reg)
            begin
              cnt_reg <= 9'h000;
              run_reg <= 1'b0;
              armed_reg <= 1'b0;
            end
            else if (run_reg)
            begin
              cnt_reg <= cnt_reg + 9'h001;
              if (cnt_full)
                ovf_reg <= 1'b1;
              if (!line_in.rx_line)
                rx_low_seen_reg <= 1'b1;
              if (arb_hit)
                armed_reg <= 1'b0;
            end
          end
        end
        default:
        begin
          // Idle and the reserved code both hold the counter cleared.
          cnt_reg <= 9'h000;
          run_reg <= 1'b0;
          armed_reg <= 1'b0;
          rx_low_seen_reg <= 1'b0;
        end
      endcase
    end
  end

  // A reload on the sampling tick wins, since the sample belongs to the
  // bit that has just ended.
  assign lost_set = mode_arb && tick && run_reg && arb_hit && !tx_rise &&
    !line_in.rx_line;
  assign lost_clr = ctl_wr && !pwdata[`SBAC_BIT_MODE_HI];

  // Lost flag: a new loss in the clearing cycle still wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lost_reg <= 1'b0;
    else if (lost_set)
      lost_reg <= 1'b1;
    else if (lost_clr)
      lost_reg <= 1'b0;
  end

  // Driving recessive keeps this node from corrupting the winning frame.
  assign tx_pin = lost_reg ? 1'b1 : line_in.internal_tx_output;

  assign rd_setup = psel && !penable && !pwrite;
  // Control byte as software sees it; the low bit is the counter MSB.
  assign ctl_view = {mode_reg, lost_reg, clksel_reg, done_reg, run_reg,
    ovf_reg, cnt_reg[8]};

  // Read data is captured in the setup cycle so it stays stable for the
  // whole access phase, even while the counter keeps moving.
  always_comb
  begin
    unique case (paddr)
      `SBAC_CTL_OFFSET:
        rd_byte = ctl_view;
      `SBAC_DAT_OFFSET:
        rd_byte = cnt_reg[7:0];
      default:
        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= {24'h000000, rd_byte};
  end
endmodule // sbac_arbiter

// File: verification/sbac_bus_model.sv
`timescale 1ns/1ps
module sbac_bus_model (
  // Clock.
  input wire logic pclk,
  // Shared bus.
  input wire logic tx_pin,
  input wire logic other_low,
  output logic rx_line,
  output logic prescaler_tick
);
  logic tog_reg = 1'b0;
  // Open-drain bus with pull-up: any node may hold it low.
  assign rx_line = tx_pin & !other_low;
  // Prescaler output pulses every second bus cycle.
  always @(posedge pclk) tog_reg <= !tog_reg;
  assign prescaler_tick = tog_reg;
endmodule // sbac_bus_model

// File: verification/sbac_arbiter_assertions.sv
`timescale 1ns/1ps
module sbac_arbiter_assertions (
  // APB side.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial side.
  input wire sbac_pkg::sbac_line_in_t line_in,
  input wire logic tx_pin
);
  import sbac_pkg::*;
  logic [1:0] mode_reg;
  logic clk_reg;
  logic rd_ctl;
  logic rd_dat;
  assign rd_ctl = psel && !penable && !pwrite && paddr == 12'h000;
  assign rd_dat = psel && !penable && !pwrite && paddr == 12'h004;
  // Shadow of the writable fields, for readback checks.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {mode_reg, clk_reg} <= 3'h0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      {mode_reg, clk_reg} <= {pwdata[7:6], pwdata[4]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_unmapped_zero: assert property (
    psel && !penable && !pwrite && paddr == 12'h008 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_data_upper: assert property (
    rd_dat |=> prdata[31:8] == 24'h0) else $error("data upper bits set");
  chk_idle_count: assert property (
    rd_dat && mode_reg == 2'h0 |=> prdata[7:0] == 8'h0)
    else $error("counter moves in idle");
  chk_idle_flags: assert property (
    rd_ctl && mode_reg == 2'h0 |=> prdata[5:0] == {1'b0, clk_reg, 4'h0})
    else $error("flags set in idle");
  chk_mode_readback: assert property (
    rd_ctl |=> prdata[7:6] == mode_reg) else $error("mode readback wrong");
  chk_clksel_readback: assert property (
    rd_ctl |=> prdata[4] == clk_reg) else $error("clock select wrong");
  chk_tx_high_pass: assert property (
    line_in.internal_tx_output |-> tx_pin) else $error("tx pin low");
  chk_tx_idle_pass: assert property (
    mode_reg == 2'h0 && !line_in.internal_tx_output |-> !tx_pin)
    else $error("tx pin forced in idle");
  chk_lost_forces: assert property (
    rd_ctl ##1 prdata[5] |-> tx_pin) else $error("lost but tx not forced");
  cover property (rd_ctl ##1 prdata[3]);
  cover property (rd_ctl ##1 prdata[1]);
  cover property (rd_ctl ##1 prdata[5]);
endmodule // sbac_arbiter_assertions

// File: verification/sbac_arbiter_bench.sv
`timescale 1ns/1ps
module sbac_arbiter_bench;
  import sbac_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, tx_pin, rx, tick;
  logic tx_out = 1'b1;
  logic other_low = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int gaps[3] = '{40, 300, 600};
  always #50 pclk = !pclk;
  sbac_arbiter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in({rx, tx_out, tick}), .tx_pin(tx_pin));
  sbac_bus_model u_bus (.pclk(pclk), .tx_pin(tx_pin),
    .other_low(other_low), .rx_line(rx), .prescaler_tick(tick));
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, exp, tol);
    check_count++;
    if (((got <= exp + tol) && (got + tol >= exp)) !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, t);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e, t);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'h000, 32'h0, 32'h0);
    rc(12'h004, 32'h0, 32'h0);
    rc(12'h008, 32'h0, 32'h0);
    xfer(1'b1, 12'h000, 32'h10);
    rc(12'h000, 32'h10, 32'h0);
    foreach (gaps[i])
    begin
      xfer(1'b1, 12'h000, 32'h40);
      other_low <= 1'b1;
      repeat (8) @(posedge pclk);
      other_low <= 1'b0;
      rc(12'h000, 32'h44, 32'h0);
      repeat (4 * gaps[i] - 11) @(posedge pclk);
      other_low <= 1'b1;
      repeat (8) @(posedge pclk);
      other_low <= 1'b0;
      rc(12'h004, gaps[i] % 256, 32'h1);
      rc(12'h000, 32'h48 | (gaps[i] % 512) / 256 | (gaps[i] / 512) * 2, 0);
    end
    xfer(1'b1, 12'h000, 32'h40);
    rc(12'h000, 32'h40, 32'h0);
    rc(12'h004, 32'h0, 32'h0);
    other_low <= 1'b1;
    xfer(1'b1, 12'h000, 32'h50);
    repeat (157) @(posedge pclk);
    other_low <= 1'b0;
    repeat (16) @(posedge pclk);
    rc(12'h004, 32'd20, 32'h2);
    rc(12'h000, 32'h58, 32'h0);
    xfer(1'b1, 12'h000, 32'h80);
    for (int k = 0; k < 2; k++)
    begin
      tx_out <= 1'b0;
      repeat (8) @(posedge pclk);
      tx_out <= 1'b1;
      other_low <= k[0];
      repeat (300) @(posedge pclk);
      other_low <= 1'b0;
      xfer(1'b0, 12'h000, 32'h0);
      chk({31'h0, rdv[5]}, k, 32'h0);
    end
    tx_out <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, tx_pin}, 32'h1, 32'h0);
    xfer(1'b1, 12'h000, 32'h0);
    rc(12'h000, 32'h0, 32'h0);
    chk({31'h0, tx_pin}, 32'h0, 32'h0);
    xfer(1'b1, 12'h000, 32'h90);
    tx_out <= 1'b1;
    other_low <= 1'b1;
    repeat (100) @(posedge pclk);
    other_low <= 1'b0;
    rc(12'h000, 32'hb4, 32'h0);
    test_done();
  end
endmodule // sbac_arbiter_bench
bind sbac_arbiter sbac_arbiter_assertions u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .line_in(line_in), .tx_pin(tx_pin));
